//--- sfs_pkg.sv
// Shared constants, states and carrier types of the fan speed serial slave
package sfs_pkg;

   // ****************************************
   // Addressing and byte layout
   // ****************************************
   localparam logic [6:0] OWN_ADDR = 7'h74;
   localparam int CODE_W = 6;
   localparam logic [5:0] ZERO_CODE_LEVEL = 6'h00;
   localparam logic [5:0] TOP_CODE_LEVEL = 6'h3f;
   localparam int SPEED_CODE_MSB = 5;
   localparam int SPEED_CODE_LSB = 0;
   localparam int KICK_CMD_BIT = 6;
   localparam int OVERHEAT_BIT = 6;
   localparam int OVERLOAD_BIT = 7;
   localparam int TX_MSB = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BITCNT_RESET = 4'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int BOOST_TIME_MS = 250;
   localparam int BOOST_CYCLES = (CLK_HZ / 1000) * BOOST_TIME_MS;

   // Synchroniser reset: bus lines idle high, comparators inactive
   localparam logic [3:0] SYNC_RESET = 4'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_IGNORE
   } sfs_state_type;

   typedef struct packed {
      logic scl_lvl;
      logic sda_lvl;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic overtemp;
      logic overload;
   } sfs_line_ev_type;

endpackage : sfs_pkg

//--- sfs_line_sync.sv
// Pin synchronisers and bus condition detector
`timescale 1ns/1ps
`default_nettype none
module sfs_line_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic overtemp_in,
   input wire logic overload_in,
   output var sfs_pkg::sfs_line_ev_type ev
);

   logic [3:0] meta;
   logic [3:0] sync;
   logic [1:0] prev;
   logic [3:0] next_meta;
   logic [3:0] next_sync;
   logic [1:0] next_prev;

   // ****************************************
   // Two-flop capture, bit order {overload, overtemp, sda, scl}
   // ****************************************
   always_comb begin
      next_meta = {overload_in, overtemp_in, sda_in, scl_in};
      next_sync = meta;
      next_prev = sync[1:0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= sfs_pkg::SYNC_RESET;
         sync <= sfs_pkg::SYNC_RESET;
         prev <= sfs_pkg::SYNC_RESET[1:0];
      end else if (ce) begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   // Edges and conditions look only at the second stage and its delayed copy
   always_comb begin
      ev.scl_lvl = sync[0];
      ev.sda_lvl = sync[1];
      ev.scl_rise = sync[0] & ~prev[0];
      ev.scl_fall = ~sync[0] & prev[0];
      ev.start = sync[0] & prev[0] & prev[1] & ~sync[1]; // RQ4
      ev.stop = sync[0] & prev[0] & ~prev[1] & sync[1]; // RQ5
      ev.overtemp = sync[2];
      ev.overload = sync[3];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_start_shape: assert property (ev.start |-> ev.scl_lvl && !ev.sda_lvl && $past(ev.sda_lvl)) // RQ4
      else $error("start flagged without sda falling under high scl");
   chk_stop_shape: assert property (ev.stop |-> ev.scl_lvl && ev.sda_lvl && !$past(ev.sda_lvl)) // RQ5
      else $error("stop flagged without sda rising under high scl");

endmodule : sfs_line_sync
`default_nettype wire

//--- sfs_boost_timer.sv
// Spin-up boost timer holding full scale after a new setting
`timescale 1ns/1ps
`default_nettype none
module sfs_boost_timer #(
   parameter int CYCLES = sfs_pkg::BOOST_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic cancel,
   output logic active
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
   localparam logic [CW-1:0] ZERO = '0;

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_active;

   // ****************************************
   // Countdown; a fresh setting restarts or cancels it
   // ****************************************
   always_comb begin
      next_cnt = cnt;
      next_active = active;
      if (start) begin
         next_cnt = LOAD; // RQ17
         next_active = 1'b1;
      end else if (cancel) begin
         next_cnt = ZERO;
         next_active = 1'b0;
      end else if (active) begin
         if (cnt == ZERO) begin
            next_active = 1'b0; // RQ17
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= ZERO;
         active <= 1'b0;
      end else if (ce) begin
         cnt <= next_cnt;
         active <= next_active;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_boost_load: assert property ((start && ce) |=> active && cnt == LOAD) // RQ17
      else $error("boost did not load its full period");
   chk_boost_end: assert property ((active && cnt == ZERO && ce && !start) |=> !active) // RQ17
      else $error("boost outlived its period");

endmodule : sfs_boost_timer
`default_nettype wire

//--- sfs_slave.sv
// Two-wire fan speed slave: send-byte speed command, receive-byte fault status
//
// Summary of operation
// RQ1 - Host makes clock; device only samples it
// RQ2 - Data bits sampled on rising clock edge
// RQ3 - Data line only pulled low or released
// RQ4 - Falling data under high clock starts
// RQ5 - Rising data under high clock stops
// RQ6 - Data held stable while clock high
// RQ7 - Seven-bit address plus direction after start
// RQ8 - Direction low writes, high reads
// RQ9 - Acknowledge matching address, ignore mismatch
// RQ10 - Acknowledge only valid address or command
// RQ11 - Host sends one command byte, MSB first
// RQ12 - Acknowledge complete command byte
// RQ13 - Latch code at acknowledge falling edge
// RQ14 - Six-bit code sets fan output level
// RQ15 - All ones full scale, zeros zero
// RQ16 - Power-up presents code zero
// RQ17 - Boost holds full scale for 250 ms
// RQ18 - Overtemperature shuts pass device, sets bit6
// RQ19 - Overload sets readback bit seven
// RQ20 - Read: acknowledge, then shift status byte
// RQ21 - Host ends read with nack, stop
// RQ22 - Fault flags readable at any time
// RQ23 - Command bits five..zero code, bit boost
// RQ24 - Readback bits five..zero read zero
// RQ25 - Early stop leaves speed code unchanged
// RQ26 - Own address fixed at 1110100
// RQ27 - After final nack release and idle
`timescale 1ns/1ps
`default_nettype none
module sfs_slave #(
   parameter int BOOST_CYCLES = sfs_pkg::BOOST_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic overtemp_in,
   input wire logic overload_in,
   output logic [sfs_pkg::CODE_W-1:0] fan_drive_output,
   output logic pass_device_off,
   output logic spinup_kick_enable,
   output logic boost_active
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta;
   logic rst_n_sync;

   // Async assert, two-flop release so all state leaves reset together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end else if (ce) begin
         rst_meta <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   // ****************************************
   // Line capture and boost timer
   // ****************************************
   sfs_pkg::sfs_line_ev_type ev;
   logic boost_start;
   logic boost_cancel;

   sfs_line_sync u_sync (
      .clk(clk),
      .rst_n(rst_n_sync),
      .ce(ce),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .overtemp_in(overtemp_in),
      .overload_in(overload_in),
      .ev(ev)
   );

   sfs_boost_timer #(
      .CYCLES(BOOST_CYCLES)
   ) u_boost (
      .clk(clk),
      .rst_n(rst_n_sync),
      .ce(ce),
      .start(boost_start),
      .cancel(boost_cancel),
      .active(boost_active)
   );

   // Status byte: faults in the top two bits, rest zero
   function automatic logic [7:0] status_byte(input logic ot, input logic ol);
      logic [7:0] b;
      b = sfs_pkg::BYTE_RESET; // RQ24
      b[sfs_pkg::OVERHEAT_BIT] = ot; // RQ18
      b[sfs_pkg::OVERLOAD_BIT] = ol; // RQ19
      return b;
   endfunction : status_byte

   // ****************************************
   // Protocol state
   // ****************************************
   sfs_pkg::sfs_state_type state;
   sfs_pkg::sfs_state_type next_state;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] tx;
   logic [7:0] next_tx;
   logic drive_low;
   logic next_drive_low;
   logic rw;
   logic next_rw;
   logic [sfs_pkg::CODE_W-1:0] speed_code;
   logic [sfs_pkg::CODE_W-1:0] next_speed_code;
   logic next_kick;
   logic [7:0] live_status;

   assign live_status = status_byte(ev.overtemp, ev.overload); // RQ22

   // Stop and start override any state; a stop never commits a half byte
   always_comb begin
      next_state = state;
      next_bitcnt = bitcnt;
      next_shift = shift;
      next_tx = tx;
      next_drive_low = drive_low;
      next_rw = rw;
      next_speed_code = speed_code;
      next_kick = spinup_kick_enable;
      boost_start = 1'b0;
      boost_cancel = 1'b0;
      if (ev.stop) begin
         next_state = sfs_pkg::ST_IDLE; // RQ5 RQ25
         next_drive_low = 1'b0;
      end else if (ev.start) begin
         next_state = sfs_pkg::ST_ADDR; // RQ4 RQ7
         next_bitcnt = sfs_pkg::BITCNT_RESET;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            sfs_pkg::ST_ADDR, sfs_pkg::ST_CMD: begin
               if (ev.scl_rise && bitcnt < sfs_pkg::BITS_PER_BYTE) begin
                  next_shift = {shift[6:0], ev.sda_lvl}; // RQ2 RQ11
                  next_bitcnt = bitcnt + 1'b1;
               end else if (ev.scl_fall && bitcnt == sfs_pkg::BITS_PER_BYTE) begin
                  next_bitcnt = sfs_pkg::BITCNT_RESET;
                  if (state == sfs_pkg::ST_CMD) begin
                     next_state = sfs_pkg::ST_CMD_ACK; // RQ12 RQ10
                     next_drive_low = 1'b1;
                  end else if (shift[7:1] == sfs_pkg::OWN_ADDR) begin
                     next_state = sfs_pkg::ST_ADDR_ACK; // RQ9 RQ26
                     next_rw = shift[0]; // RQ8
                     next_drive_low = 1'b1;
                  end else begin
                     next_state = sfs_pkg::ST_IGNORE; // RQ9 RQ10
                  end
               end
            end
            sfs_pkg::ST_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  next_bitcnt = sfs_pkg::BITCNT_RESET;
                  if (rw) begin
                     next_state = sfs_pkg::ST_TX; // RQ20
                     next_tx = live_status;
                     next_drive_low = ~live_status[sfs_pkg::TX_MSB];
                  end else begin
                     next_state = sfs_pkg::ST_CMD;
                     next_drive_low = 1'b0;
                  end
               end
            end
            sfs_pkg::ST_CMD_ACK: begin
               if (ev.scl_fall) begin
                  // Commit only here, so a stop before this edge leaves the code alone
                  next_speed_code = shift[sfs_pkg::SPEED_CODE_MSB:sfs_pkg::SPEED_CODE_LSB]; // RQ13 RQ23
                  next_kick = shift[sfs_pkg::KICK_CMD_BIT]; // RQ23
                  boost_start = shift[sfs_pkg::KICK_CMD_BIT]; // RQ17
                  boost_cancel = ~shift[sfs_pkg::KICK_CMD_BIT];
                  next_drive_low = 1'b0;
                  next_state = sfs_pkg::ST_IGNORE; // RQ11
               end
            end
            sfs_pkg::ST_TX: begin
               if (ev.scl_rise) begin
                  next_bitcnt = bitcnt + 1'b1;
               end else if (ev.scl_fall) begin
                  if (bitcnt == sfs_pkg::BITS_PER_BYTE) begin
                     next_state = sfs_pkg::ST_TX_ACK; // RQ21
                     next_drive_low = 1'b0;
                  end else begin
                     next_tx = {tx[6:0], 1'b0}; // RQ20
                     next_drive_low = ~tx[sfs_pkg::TX_MSB - 1]; // RQ3 RQ6
                  end
               end
            end
            sfs_pkg::ST_TX_ACK: begin
               if (ev.scl_rise && ev.sda_lvl) begin
                  next_state = sfs_pkg::ST_IDLE; // RQ27
               end else if (ev.scl_fall) begin
                  // Host acked: keep serving fresh status
                  next_state = sfs_pkg::ST_TX;
                  next_bitcnt = sfs_pkg::BITCNT_RESET;
                  next_tx = live_status;
                  next_drive_low = ~live_status[sfs_pkg::TX_MSB];
               end
            end
            sfs_pkg::ST_IDLE, sfs_pkg::ST_IGNORE: begin
               next_drive_low = 1'b0;
            end
            default: begin
               next_state = sfs_pkg::ST_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state <= sfs_pkg::ST_IDLE;
         bitcnt <= sfs_pkg::BITCNT_RESET;
         shift <= sfs_pkg::BYTE_RESET;
         tx <= sfs_pkg::BYTE_RESET;
         drive_low <= 1'b0;
         rw <= 1'b0;
         speed_code <= sfs_pkg::ZERO_CODE_LEVEL; // RQ16
         spinup_kick_enable <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         bitcnt <= next_bitcnt;
         shift <= next_shift;
         tx <= next_tx;
         drive_low <= next_drive_low;
         rw <= next_rw;
         speed_code <= next_speed_code;
         spinup_kick_enable <= next_kick;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic [sfs_pkg::CODE_W-1:0] next_fan;
   logic next_pass_off;

   // Boost overrides the programmed code; code maps straight to level
   always_comb begin
      next_fan = boost_active ? sfs_pkg::TOP_CODE_LEVEL : speed_code; // RQ14 RQ15 RQ17
      next_pass_off = ev.overtemp; // RQ18
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         fan_drive_output <= sfs_pkg::ZERO_CODE_LEVEL; // RQ16
         pass_device_off <= 1'b0;
      end else if (ce) begin
         fan_drive_output <= next_fan;
         pass_device_off <= next_pass_off;
      end
   end

   // Open drain: data only ever low, enable active low
   assign sda_out = 1'b0; // RQ3
   assign sda_oe_n = ~drive_low; // RQ3

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_sync);

   chk_open_drain: assert property (sda_out == 1'b0) // RQ3
      else $error("data line driven high");
   chk_shift_rise: assert property ( // RQ2
      (state == sfs_pkg::ST_ADDR && !ev.scl_rise && !ev.start && ce) |=> $stable(shift))
      else $error("shift register moved without a rising clock");
   chk_start_addr: assert property ( // RQ4
      (ev.start && !ev.stop && ce) |=> state == sfs_pkg::ST_ADDR && bitcnt == sfs_pkg::BITCNT_RESET)
      else $error("start did not open address phase");
   chk_stop_idle: assert property ((ev.stop && ce) |=> state == sfs_pkg::ST_IDLE && !drive_low) // RQ5
      else $error("stop did not return to idle");
   chk_drive_stable: assert property ( // RQ6
      (ce && $changed(drive_low)) |-> !$past(ev.scl_lvl) || $past(ev.start) || $past(ev.stop))
      else $error("data drive changed while clock high");
   chk_drive_window: assert property (!sda_oe_n |-> // RQ10
      state inside {sfs_pkg::ST_ADDR_ACK, sfs_pkg::ST_CMD_ACK, sfs_pkg::ST_TX})
      else $error("data line pulled outside an acknowledge or status bit");
   chk_addr_nack: assert property ( // RQ9
      (state == sfs_pkg::ST_ADDR && ev.scl_fall && bitcnt == sfs_pkg::BITS_PER_BYTE && !ev.start && !ev.stop && ce
      && shift[7:1] != sfs_pkg::OWN_ADDR) |=> state == sfs_pkg::ST_IGNORE && !drive_low)
      else $error("foreign address acknowledged");
   chk_cmd_ack: assert property (state == sfs_pkg::ST_CMD_ACK |-> drive_low) // RQ12
      else $error("command byte not acknowledged");
   chk_latch_fall: assert property ( // RQ13
      (state == sfs_pkg::ST_CMD_ACK && ev.scl_fall && !ev.stop && !ev.start && ce)
      |=> speed_code == $past(shift[sfs_pkg::SPEED_CODE_MSB:sfs_pkg::SPEED_CODE_LSB]))
      else $error("code not latched at acknowledge fall");
   chk_stop_keep: assert property ((state == sfs_pkg::ST_CMD && ev.stop && ce) |=> $stable(speed_code)) // RQ25
      else $error("early stop changed speed code");
   chk_status_load: assert property ( // RQ24
      (state == sfs_pkg::ST_ADDR_ACK && rw && ev.scl_fall && !ev.stop && !ev.start && ce)
      |=> tx[5:0] == 6'h00 && tx[7:6] == {$past(ev.overload), $past(ev.overtemp)})
      else $error("status byte loaded wrongly");
   chk_boost_full: assert property ((boost_active && ce) |=> fan_drive_output == sfs_pkg::TOP_CODE_LEVEL) // RQ17
      else $error("boost did not force full scale");
   chk_nack_idle: assert property ( // RQ27
      (state == sfs_pkg::ST_TX_ACK && ev.scl_rise && ev.sda_lvl && !ev.stop && !ev.start && ce)
      |=> state == sfs_pkg::ST_IDLE && !drive_low)
      else $error("final nack did not release the line");

   cov_send_byte: cover property (state == sfs_pkg::ST_CMD_ACK && ev.scl_fall);
   cov_read_nack: cover property (state == sfs_pkg::ST_TX_ACK && ev.scl_rise && ev.sda_lvl);
   cov_boost_run: cover property ($fell(boost_active));
   cov_addr_miss: cover property (state == sfs_pkg::ST_ADDR ##1 state == sfs_pkg::ST_IGNORE);
   cov_status_again: cover property (state == sfs_pkg::ST_TX_ACK && ev.scl_fall);

endmodule : sfs_slave
`default_nettype wire

//--- sfs_host_model.sv
// Host side model: makes the bus clock and drives data for send and receive byte
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model (
   output logic scl,
   output logic sda_oe_n,
   input wire logic sda
);
   // Half of the 200 ns bus clock period
   localparam time HALF = 100ns;

   // Bus idles with both lines released; the clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end

   // One bit: data moves only in the low phase and is sampled late in the high phase
   task automatic clock_bit(input logic b, output logic s);
      #40 sda_oe_n = b;
      #60 scl = 1'b1;
      #75 s = sda;
      #25 scl = 1'b0;
   endtask : clock_bit

   // Data falls while the clock is high
   task automatic start_cond;
      sda_oe_n = 1'b0;
      #HALF scl = 1'b0;
   endtask : start_cond

   // Data rises while the clock is high, then the bus rests
   task automatic stop_cond;
      #40 sda_oe_n = 1'b0;
      #60 scl = 1'b1;
      #HALF sda_oe_n = 1'b1;
      #HALF;
   endtask : stop_cond

   // Eight bits MSB first, then the slave's acknowledge slot (low means taken)
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(b[i], s);
      end
      clock_bit(1'b1, ack);
   endtask : put_byte

   // Eight bits from the slave with the line released, then our own answer bit
   task automatic get_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         b[i] = s;
      end
      clock_bit(nack, s);
   endtask : get_byte
endmodule : sfs_host_model
`default_nettype wire

//--- smbus_fan_speed_slave_bench.sv
// Self-checking bench of the fan speed serial slave
`timescale 1ns/1ps
`default_nettype none
module smbus_fan_speed_slave_bench;
   // Short boost keeps the run brief; expectations follow it
   localparam int BOOST = 50;
   localparam int CEILING = 20000;
   logic clk = 1'b0;
   logic rst_n;
   logic overtemp;
   logic overload;
   logic sda_out;
   logic dut_oe_n;
   logic host_oe_n;
   logic scl;
   wire sda;
   logic [5:0] fan_code;
   logic pass_off;
   logic kick;
   logic boost;
   logic ce_en;
   logic a;
   logic c;
   logic [7:0] cmd;
   logic [7:0] rd;
   logic [5:0] code;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   integer seed = 32'h08d1;

   // Pulled-up wire: low when either party pulls it
   assign sda = (!host_oe_n || (!dut_oe_n && !sda_out)) ? 1'b0 : 1'b1;

   sfs_slave #(.BOOST_CYCLES(BOOST)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(ce_en), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(dut_oe_n), .overtemp_in(overtemp),
      .overload_in(overload), .fan_drive_output(fan_code), .pass_device_off(pass_off),
      .spinup_kick_enable(kick), .boost_active(boost));

   sfs_host_model host_u (.scl(scl), .sda_oe_n(host_oe_n), .sda(sda));

   always #12.5 clk = ~clk;

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic conclude;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // A hang counts as a mismatch and still reaches the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == CEILING) begin
         mismatches++;
         conclude();
      end
   end

   // Readback byte: overload on top, overheat below, low six bits zero
   function automatic logic [7:0] exp_status(input logic ol, input logic ot);
      return {ol, ot, 6'h00};
   endfunction : exp_status

   // Inputs move one small step after the clock edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic write_cmd(input logic [7:0] adr, input logic [7:0] b);
      host_u.start_cond();
      host_u.put_byte(adr, a);
      host_u.put_byte(b, c);
      host_u.stop_cond();
      settle(1);
   endtask : write_cmd

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      ce_en = 1'b1;
      overtemp = 1'b0;
      overload = 1'b0;
      settle(2);
      rst_n = 1'b1;
      settle(8);
      check_val({2'h0, fan_code}, 8'h00);
      check_bit(dut_oe_n, 1'b1);
      // Corner codes first, then random ones with the boost bit clear
      for (int i = 0; i < 10; i++) begin
         cmd = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : (i == 2) ? 8'h95 : 8'($random(seed)) & 8'hbf;
         write_cmd(8'he8, cmd);
         check_bit(a, 1'b0);
         check_bit(c, 1'b0);
         check_val({2'h0, fan_code}, {2'h0, cmd[5:0]});
         check_bit(kick, 1'b0);
      end
      code = cmd[5:0];
      // Every single-bit miss of the own address is ignored
      for (int i = 0; i < 7; i++) begin
         write_cmd(8'he8 ^ (8'h02 << i), 8'h2a);
         check_bit(a, 1'b1);
         check_bit(c, 1'b1);
         check_val({2'h0, fan_code}, {2'h0, code});
      end
      // Stop before any command byte leaves the code alone
      host_u.start_cond();
      host_u.put_byte(8'he8, a);
      host_u.stop_cond();
      settle(2);
      check_val({2'h0, fan_code}, {2'h0, code});
      // Boost holds full scale, then the programmed code takes over
      write_cmd(8'he8, 8'h45);
      check_bit(boost, 1'b1);
      check_bit(kick, 1'b1);
      check_val({2'h0, fan_code}, 8'h3f);
      settle(BOOST + 5);
      check_bit(boost, 1'b0);
      check_val({2'h0, fan_code}, 8'h05);
      write_cmd(8'he8, 8'h07);
      check_bit(kick, 1'b0);
      // Clock enable low freezes every flop, the synchronisers included
      ce_en = 1'b0;
      overtemp = 1'b1;
      settle(6);
      check_bit(pass_off, 1'b0);
      ce_en = 1'b1;
      settle(6);
      check_bit(pass_off, 1'b1);
      // Status readback: all fault pairs, then random ones
      for (int i = 0; i < 8; i++) begin
         overtemp = (i < 4) ? i[0] : 1'($random(seed));
         overload = (i < 4) ? i[1] : 1'($random(seed));
         settle(6);
         check_bit(pass_off, overtemp);
         host_u.start_cond();
         host_u.put_byte(8'he9, a);
         host_u.get_byte(1'b1, rd);
         host_u.stop_cond();
         settle(1);
         check_bit(a, 1'b0);
         check_val(rd, exp_status(overload, overtemp));
         check_bit(dut_oe_n, 1'b1);
      end
      // Host ack makes the slave send fresh status again until the nack
      host_u.start_cond();
      host_u.put_byte(8'he9, a);
      host_u.get_byte(1'b0, rd);
      check_val(rd, exp_status(overload, overtemp));
      host_u.get_byte(1'b1, rd);
      host_u.stop_cond();
      settle(1);
      check_val(rd, exp_status(overload, overtemp));
      check_bit(dut_oe_n, 1'b1);
      check_val({2'h0, fan_code}, 8'h07);
      // Reset in mid-run, after a boosted setting, brings back code zero
      write_cmd(8'he8, 8'h45);
      rst_n = 1'b0;
      settle(2);
      check_val({2'h0, fan_code}, 8'h00);
      rst_n = 1'b1;
      settle(8);
      check_bit(boost, 1'b0);
      check_bit(kick, 1'b0);
      check_val({2'h0, fan_code}, 8'h00);
      write_cmd(8'he8, 8'h11);
      check_val({2'h0, fan_code}, 8'h11);
      conclude();
   end
endmodule : smbus_fan_speed_slave_bench
`default_nettype wire
